// File: inc/port_detection_sequencer_pkg.sv
// Constants and types shared by the port detection sequencer.
package port_detection_sequencer_pkg;

	// Register bus widths.
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// Register offsets.
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CMD = 4'h1;
	localparam logic [3:0] OFS_DET_STATUS = 4'h2;
	localparam logic [3:0] OFS_PORT_STATUS = 4'h3;
	localparam logic [3:0] OFS_CLASS = 4'h4;
	localparam logic [3:0] OFS_TWO_PAIR_LIMIT = 4'h5;
	localparam logic [3:0] OFS_FOUR_PAIR_LIMIT = 4'h6;
	localparam logic [3:0] OFS_HOLD_THRESHOLD = 4'h7;

	// Control register fields.
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_DET_EN = 2;
	localparam int unsigned CTRL_CLS_EN = 3;
	localparam int unsigned CTRL_FOUR_PAIR = 4;
	localparam int unsigned CTRL_LEGACY = 5;
	localparam int unsigned CTRL_DISC_EN = 6;
	localparam int unsigned CTRL_RESET_ALL = 7;

	// Command register bits, each a one-shot on write.
	localparam int unsigned CMD_DETECT = 0;
	localparam int unsigned CMD_PWR_ON = 1;
	localparam int unsigned CMD_PWR_OFF = 2;
	localparam int unsigned CMD_CLR_FAULT = 3;

	// Control reset values chosen by the power-mode strap.
	localparam logic [7:0] CTRL_RST_AUTO = 8'h5F;
	localparam logic [7:0] CTRL_RST_OFF = 8'h40;

	// Port operating modes.
	typedef enum logic [1:0] {
		MODE_SHUTDOWN = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_SEMI = 2'h2,
		MODE_AUTO = 2'h3
	} port_mode_t;

	// Per-channel detection results.
	typedef enum logic [3:0] {
		DET_UNKNOWN = 4'h0,
		DET_SHORT = 4'h1,
		DET_CAP_HIGH = 4'h2,
		DET_R_LOW = 4'h3,
		DET_VALID = 4'h4,
		DET_R_HIGH = 4'h5,
		DET_OPEN = 4'h6,
		DET_OTHER_SRC = 4'h7,
		DET_SW_FAULT = 4'h8
	} det_result_t;

	// Connection check results.
	typedef enum logic [1:0] {
		CONN_UNKNOWN = 2'h0,
		CONN_SINGLE = 2'h1,
		CONN_DUAL = 2'h2,
		CONN_INVALID = 2'h3
	} conn_result_t;

	// Measurement steps asked of the analog front end.
	typedef enum logic [2:0] {
		STEP_I_LO = 3'h0,
		STEP_I_HI = 3'h1,
		STEP_V_LO = 3'h2,
		STEP_V_HI = 3'h3,
		STEP_CC_BASE = 3'h4,
		STEP_CC_AGGR = 3'h5
	} meas_step_t;

	// Measurement request and answer.
	typedef struct packed {
		meas_step_t step;
		logic chan;
	} meas_cmd_t;
	typedef struct packed {
		logic [11:0] value;
		logic cap_high;
		logic other_src;
		logic sw_fault;
	} meas_rsp_t;

	// Limits loaded in auto mode.
	typedef struct packed {
		logic [7:0] two_pair;
		logic [7:0] four_pair;
		logic [7:0] hold;
	} limits_t;

	// Reading thresholds: volts in 10 mV counts, currents in 1 uA counts.
	localparam logic [11:0] V_SHORT_CNT = 12'h064;
	localparam logic [11:0] V_MAX_CNT = 12'h3E8;
	localparam logic [11:0] DV_17K_CNT = 12'h0AA;
	localparam logic [11:0] DV_29K_CNT = 12'h122;
	localparam logic [11:0] DV_50K_CNT = 12'h1F4;
	localparam logic [11:0] DI_17K_CNT = 12'h0EB;
	localparam logic [11:0] DI_29K_CNT = 12'h089;
	localparam logic [11:0] CC_DUAL_MAX = 12'h014;
	localparam logic [11:0] CC_CHANGE_MIN = 12'h0C8;

	// Class code for class 4+ limited to legacy operation.
	localparam logic [3:0] CLASS_4P_TYPE1 = 4'h9;

	// Power limits in 0.5 W steps and hold currents in 0.5 mA steps.
	localparam logic [7:0] LIM_4W = 8'h08;
	localparam logic [7:0] LIM_7W = 8'h0E;
	localparam logic [7:0] LIM_15W5 = 8'h1F;
	localparam logic [7:0] LIM_30W = 8'h3C;
	localparam logic [7:0] LIM_32W = 8'h40;
	localparam logic [7:0] LIM_39W5 = 8'h4F;
	localparam logic [7:0] LIM_45W = 8'h5A;
	localparam logic [7:0] LIM_45W5 = 8'h5B;
	localparam logic [7:0] LIM_54W = 8'h6C;
	localparam logic [7:0] LIM_60W = 8'h78;
	localparam logic [7:0] LIM_75W = 8'h96;
	localparam logic [7:0] LIM_90W = 8'hB4;
	localparam logic [7:0] HOLD_7MA0 = 8'h0E;
	localparam logic [7:0] HOLD_3MA5 = 8'h07;

	// Pause between repeated detection cycles.
	localparam int unsigned REDETECT_WAIT_MS = 100;
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned REDETECT_WAIT_CYC = REDETECT_WAIT_MS * (CLK_FREQ_HZ / 1000);

endpackage

// File: design/port_detection_sequencer.sv
// Detection, connection check and power sequencer for one two-channel port.
`timescale 1ns/1ps

// Summary of operation
// - Reset events reload configuration from power-mode strap.
// - Strap changes ignored until the next reset.
// - Spare mode strap has no effect.
// - Auto mode repeats detection, powers, removes power.
// - Class 0-4 limits per class, 7.0mA hold.
// - Classes 5-8 two/four-pair limits, 3.5mA hold.
// - Dual-signature limits per class, four-pair 90W.
// - Class 0-4 pair count follows the setting.
// - Connection check: two readings, aggressor on second.
// - Load change during check gives invalid.
// - Connection check only four-pair, not legacy mode.
// - Forced current first, forced voltage only if valid.
// - Resistance 17k to 29k reports valid.
// - Below 1V on forced current aborts as short.
// - Detection status encodings; non-valid invalidates check.
// - Each channel detected and reported separately.
// - Manual mode runs one detection per command.
// - Semi-auto polls, never powers without command.
// - Semi-auto classifies, waits 100ms, detects again.
// - Power-on needs valid detection, else start fault.
// - Auto powers after valid detection and classification.
// - Shutdown or detect-enable cleared stops detection.
// - Mode codes: auto 11, semi 10, manual 01.
// - Faults and enabled disconnects remove power.
module port_detection_sequencer
	import port_detection_sequencer_pkg::*;
#(
	parameter int unsigned REDETECT_WAIT_CYCLES = REDETECT_WAIT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_power_mode_strap,
	input wire logic i_spare_mode_strap,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_meas_req,
	output meas_cmd_t o_meas_cmd,
	input wire logic i_meas_done,
	input wire meas_rsp_t i_meas_rsp,
	output logic o_class_req,
	input wire logic i_class_done,
	input wire logic [3:0] i_class_result,
	input wire logic [1:0] i_chan_fault,
	input wire logic [1:0] i_disconnect,
	output logic [1:0] o_pwr_en,
	output limits_t o_limits
);

	// Sequencer states, Gray coded along the detection path.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_CC_BASE = 4'h1,
		ST_CC_AGGR = 4'h3,
		ST_I_LO = 4'h2,
		ST_I_HI = 4'h6,
		ST_V_LO = 4'h7,
		ST_V_HI = 4'h5,
		ST_CLASS = 4'h4,
		ST_WAIT = 4'hC
	} seq_state_t;

	seq_state_t state_q, state_d; // Sequencer state.
	logic chan_q, chan_d; // Channel under detection.
	logic [11:0] first_q; // First reading of a differenced pair.
	logic [31:0] wait_q; // Redetection pause counter.
	logic strap_pend_q; // Configuration reload pending.
	logic [7:0] ctrl_q; // Control register.
	logic manual_pend_q; // Host detect command not yet served.
	det_result_t det_q [2]; // Per-channel detection status.
	conn_result_t conn_q; // Connection check status.
	logic cc_ran_q; // This cycle ran a connection check.
	logic [3:0] class_q; // Assigned class.
	logic class_ok_q; // Class result belongs to the current load.
	logic [1:0] pwr_q; // Channel power enables.
	logic start_fault_q; // Power-on refused fault, sticky.
	limits_t lim_q; // Active power limits and hold threshold.
	logic [DATA_W-1:0] rd_q; // Read data register.

	// Combinational helpers.
	port_mode_t mode;
	logic det_allowed, cc_needed, start, chan_fin, class_fin;
	det_result_t det_res;
	logic cc_done;
	conn_result_t cc_res;
	logic wr_cmd, pwr_on_cmd, pwr_off_cmd, clr_fault_cmd, detect_cmd;
	logic [1:0] pwr_mask, kill;
	logic port_ok;

	// Flags from the front end that end a step with a fixed verdict.
	function automatic det_result_t flag_result(input meas_rsp_t r);
		if (r.sw_fault) begin
			return DET_SW_FAULT;
		end else if (r.other_src) begin
			return DET_OTHER_SRC;
		end else if (r.cap_high || r.value > V_MAX_CNT) begin
			return DET_CAP_HIGH;
		end
		return DET_VALID;
	endfunction

	// Forced-current verdict from the voltage difference.
	function automatic det_result_t eval_current(input logic [11:0] v1, input meas_rsp_t r);
		logic [11:0] dv;
		dv = r.value - v1;
		if (flag_result(r) != DET_VALID) begin
			return flag_result(r);
		end else if (r.value <= v1 || dv < DV_17K_CNT) begin
			return DET_R_LOW;
		end else if (dv > DV_50K_CNT) begin
			return DET_OPEN;
		end else if (dv > DV_29K_CNT) begin
			return DET_R_HIGH;
		end
		return DET_VALID;
	endfunction

	// Forced-voltage verdict from the current difference.
	function automatic det_result_t eval_voltage(input logic [11:0] i1, input meas_rsp_t r);
		logic [11:0] di;
		di = r.value - i1;
		if (flag_result(r) != DET_VALID) begin
			return flag_result(r);
		end else if (r.value <= i1) begin
			return DET_OPEN;
		end else if (di > DI_17K_CNT) begin
			return DET_R_LOW;
		end else if (di < DI_29K_CNT) begin
			return DET_R_HIGH;
		end
		return DET_VALID;
	endfunction

	// Limits for an assigned class and load type.
	function automatic limits_t class_limits(input logic [3:0] cls, input logic dual);
		limits_t l;
		l = '{two_pair: LIM_15W5, four_pair: LIM_15W5, hold: HOLD_7MA0};
		if (dual) begin
			l.four_pair = LIM_90W;
			l.hold = HOLD_3MA5;
			case (cls)
				4'h1: l.two_pair = LIM_4W;
				4'h2: l.two_pair = LIM_7W;
				4'h3: l.two_pair = LIM_15W5;
				4'h4: l.two_pair = LIM_30W;
				default: l.two_pair = LIM_45W;
			endcase
		end else begin
			case (cls)
				4'h1: l = '{two_pair: LIM_4W, four_pair: LIM_4W, hold: HOLD_7MA0};
				4'h2: l = '{two_pair: LIM_7W, four_pair: LIM_7W, hold: HOLD_7MA0};
				4'h4: l = '{two_pair: LIM_30W, four_pair: LIM_30W, hold: HOLD_7MA0};
				4'h5: l = '{two_pair: LIM_32W, four_pair: LIM_45W, hold: HOLD_3MA5};
				4'h6: l = '{two_pair: LIM_39W5, four_pair: LIM_60W, hold: HOLD_3MA5};
				4'h7: l = '{two_pair: LIM_45W5, four_pair: LIM_75W, hold: HOLD_3MA5};
				4'h8: l = '{two_pair: LIM_54W, four_pair: LIM_90W, hold: HOLD_3MA5};
				default: l = '{two_pair: LIM_15W5, four_pair: LIM_15W5, hold: HOLD_7MA0};
			endcase
		end
		return l;
	endfunction

	// Decoded configuration and host commands.
	always_comb begin
		mode = port_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
		det_allowed = mode != MODE_SHUTDOWN && ctrl_q[CTRL_DET_EN];
		cc_needed = ctrl_q[CTRL_FOUR_PAIR] && !ctrl_q[CTRL_LEGACY];
		wr_cmd = i_wr && i_addr == OFS_CMD;
		detect_cmd = wr_cmd && i_wr_data[CMD_DETECT];
		pwr_on_cmd = wr_cmd && i_wr_data[CMD_PWR_ON];
		pwr_off_cmd = wr_cmd && i_wr_data[CMD_PWR_OFF];
		clr_fault_cmd = wr_cmd && i_wr_data[CMD_CLR_FAULT];
		// Manual runs on command; semi-auto and auto poll while unpowered.
		start = det_allowed && (mode == MODE_MANUAL ? manual_pend_q : pwr_q == 2'h0);
	end

	// Channels to power and whether their detections allow it.
	always_comb begin
		if (conn_q == CONN_DUAL || (cc_ran_q && class_q > 4'h4 && class_q != CLASS_4P_TYPE1)) begin
			pwr_mask = 2'h3;
		end else if (cc_ran_q && ctrl_q[CTRL_FOUR_PAIR]) begin
			pwr_mask = 2'h3;
		end else begin
			pwr_mask = 2'h1;
		end
		port_ok = det_q[0] == DET_VALID && (!pwr_mask[1] || det_q[1] == DET_VALID);
		kill = i_chan_fault | (i_disconnect & {2{ctrl_q[CTRL_DISC_EN]}});
	end

	// Next-state logic of the detection sequence.
	always_comb begin
		state_d = state_q;
		chan_d = chan_q;
		chan_fin = 1'b0;
		class_fin = 1'b0;
		det_res = DET_UNKNOWN;
		cc_done = 1'b0;
		cc_res = CONN_UNKNOWN;
		case (state_q)
			ST_IDLE: if (start) begin
				chan_d = 1'b0;
				state_d = cc_needed ? ST_CC_BASE : ST_I_LO;
			end
			ST_CC_BASE: if (i_meas_done) begin
				state_d = ST_CC_AGGR;
			end
			ST_CC_AGGR: if (i_meas_done) begin
				cc_done = 1'b1;
				state_d = ST_I_LO;
				if (i_meas_rsp.value > first_q + CC_CHANGE_MIN ||
					first_q > i_meas_rsp.value + CC_CHANGE_MIN) begin
					cc_res = CONN_INVALID;
				end else if (i_meas_rsp.value > first_q + CC_DUAL_MAX ||
					first_q > i_meas_rsp.value + CC_DUAL_MAX) begin
					cc_res = CONN_SINGLE;
				end else begin
					cc_res = CONN_DUAL;
				end
			end
			ST_I_LO: if (i_meas_done) begin
				if (i_meas_rsp.value < V_SHORT_CNT) begin
					det_res = DET_SHORT;
					chan_fin = 1'b1;
				end else begin
					state_d = ST_I_HI;
				end
			end
			ST_I_HI: if (i_meas_done) begin
				det_res = i_meas_rsp.value < V_SHORT_CNT ? DET_SHORT : eval_current(first_q, i_meas_rsp);
				if (det_res == DET_VALID) begin
					state_d = ST_V_LO;
				end else begin
					chan_fin = 1'b1;
				end
			end
			ST_V_LO: if (i_meas_done) begin
				state_d = ST_V_HI;
			end
			ST_V_HI: if (i_meas_done) begin
				det_res = eval_voltage(first_q, i_meas_rsp);
				chan_fin = 1'b1;
			end
			ST_CLASS: if (i_class_done) begin
				class_fin = 1'b1;
				state_d = mode == MODE_MANUAL ? ST_IDLE : ST_WAIT;
			end
			ST_WAIT: if (wait_q == 32'h0) begin
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
		// After one channel the other follows; the last picks class, or else the pause (idle in manual mode).
		if (chan_fin) begin
			if (!chan_q) begin
				chan_d = 1'b1;
				state_d = ST_I_LO;
			end else if (ctrl_q[CTRL_CLS_EN] && (det_q[0] == DET_VALID || det_res == DET_VALID)) begin
				state_d = ST_CLASS;
			end else begin
				state_d = mode == MODE_MANUAL ? ST_IDLE : ST_WAIT;
			end
		end
		if (!det_allowed) begin
			state_d = ST_IDLE;
		end
	end

	// Measurement and classification requests follow the state.
	always_comb begin
		o_meas_req = state_q inside {ST_CC_BASE, ST_CC_AGGR, ST_I_LO, ST_I_HI, ST_V_LO, ST_V_HI};
		o_class_req = state_q == ST_CLASS;
		o_meas_cmd.chan = state_q inside {ST_CC_BASE, ST_CC_AGGR} ? 1'b0 : chan_q;
		case (state_q)
			ST_CC_BASE: o_meas_cmd.step = STEP_CC_BASE;
			ST_CC_AGGR: o_meas_cmd.step = STEP_CC_AGGR;
			ST_I_HI: o_meas_cmd.step = STEP_I_HI;
			ST_V_LO: o_meas_cmd.step = STEP_V_LO;
			ST_V_HI: o_meas_cmd.step = STEP_V_HI;
			default: o_meas_cmd.step = STEP_I_LO;
		endcase
	end

	// Reload flag: set by reset or a reset-all write, served next edge.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			strap_pend_q <= 1'b1;
		end else begin
			strap_pend_q <= i_wr && i_addr == OFS_CTRL && i_wr_data[CTRL_RESET_ALL];
		end
	end

	// Control register; the strap is looked at only while reloading.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q <= CTRL_RST_OFF;
		end else if (strap_pend_q) begin
			ctrl_q <= i_power_mode_strap ? CTRL_RST_AUTO : CTRL_RST_OFF;
		end else if (i_wr && i_addr == OFS_CTRL && !i_wr_data[CTRL_RESET_ALL]) begin
			ctrl_q <= {1'b0, i_wr_data[6:0]};
		end
	end

	// Sequencer registers and the first reading of each pair.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			chan_q <= 1'b0;
			first_q <= 12'h000;
			wait_q <= 32'h0;
		end else if (strap_pend_q) begin
			state_q <= ST_IDLE;
			chan_q <= 1'b0;
			wait_q <= 32'h0;
		end else begin
			state_q <= state_d;
			chan_q <= chan_d;
			if (i_meas_done && state_q inside {ST_CC_BASE, ST_I_LO, ST_V_LO}) begin
				first_q <= i_meas_rsp.value;
			end
			// The pause counts from entry into the wait state.
			if (state_d == ST_WAIT && state_q != ST_WAIT) begin
				wait_q <= 32'(REDETECT_WAIT_CYCLES - 1);
			end else if (wait_q != 32'h0) begin
				wait_q <= wait_q - 32'h1;
			end
		end
	end

	// Status fields, updated as each result arrives.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			det_q <= '{DET_UNKNOWN, DET_UNKNOWN};
			conn_q <= CONN_UNKNOWN;
			cc_ran_q <= 1'b0;
			class_q <= 4'h0;
			class_ok_q <= 1'b0;
			manual_pend_q <= 1'b0;
		end else if (strap_pend_q) begin
			det_q <= '{DET_UNKNOWN, DET_UNKNOWN};
			conn_q <= CONN_UNKNOWN;
			cc_ran_q <= 1'b0;
			class_q <= 4'h0;
			class_ok_q <= 1'b0;
			manual_pend_q <= 1'b0;
		end else begin
			// A new command arriving while one starts is kept.
			manual_pend_q <= detect_cmd || (manual_pend_q && !(state_q == ST_IDLE && start));
			if (state_q == ST_IDLE && start) begin
				cc_ran_q <= cc_needed;
				class_ok_q <= 1'b0;
				if (!cc_needed) begin
					conn_q <= CONN_UNKNOWN;
				end
			end
			if (cc_done) begin
				conn_q <= cc_res;
			end
			if (chan_fin) begin
				det_q[chan_q] <= det_res;
				if (det_res != DET_VALID && cc_ran_q) begin
					conn_q <= CONN_INVALID;
				end
			end
			if (class_fin) begin
				class_q <= i_class_result;
				class_ok_q <= 1'b1;
			end
		end
	end

	// Power enables, start fault and the limit set.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pwr_q <= 2'h0;
			start_fault_q <= 1'b0;
			lim_q <= '{two_pair: LIM_15W5, four_pair: LIM_15W5, hold: HOLD_7MA0};
		end else if (strap_pend_q) begin
			pwr_q <= 2'h0;
			start_fault_q <= 1'b0;
			lim_q <= '{two_pair: LIM_15W5, four_pair: LIM_15W5, hold: HOLD_7MA0};
		end else begin
			if (mode == MODE_SHUTDOWN || pwr_off_cmd) begin
				pwr_q <= 2'h0;
			end else if (kill != 2'h0) begin
				// A single-signature load loses both pairs together.
				pwr_q <= conn_q == CONN_DUAL ? pwr_q & ~kill : 2'h0;
			end else if (pwr_on_cmd && port_ok) begin
				pwr_q <= pwr_mask;
			end else if (mode == MODE_AUTO && class_ok_q && port_ok && pwr_q == 2'h0 &&
				state_q == ST_WAIT) begin
				pwr_q <= pwr_mask;
				lim_q <= class_limits(class_q, conn_q == CONN_DUAL);
			end
			// A refused power-on wins over a clear in the same cycle.
			if (pwr_on_cmd && (!port_ok || mode == MODE_SHUTDOWN)) begin
				start_fault_q <= 1'b1;
			end else if (clr_fault_cmd) begin
				start_fault_q <= 1'b0;
			end
			if (i_wr && i_addr == OFS_TWO_PAIR_LIMIT) begin
				lim_q.two_pair <= i_wr_data;
			end
			if (i_wr && i_addr == OFS_FOUR_PAIR_LIMIT) begin
				lim_q.four_pair <= i_wr_data;
			end
			if (i_wr && i_addr == OFS_HOLD_THRESHOLD) begin
				lim_q.hold <= i_wr_data;
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_q <= 8'h00;
		end else if (!i_rd) begin
			rd_q <= 8'h00;
		end else begin
			case (i_addr)
				OFS_CTRL: rd_q <= ctrl_q;
				OFS_DET_STATUS: rd_q <= {det_q[1], det_q[0]};
				OFS_PORT_STATUS: rd_q <= {3'h0, start_fault_q, pwr_q, conn_q};
				OFS_CLASS: rd_q <= {3'h0, class_ok_q, class_q};
				OFS_TWO_PAIR_LIMIT: rd_q <= lim_q.two_pair;
				OFS_FOUR_PAIR_LIMIT: rd_q <= lim_q.four_pair;
				OFS_HOLD_THRESHOLD: rd_q <= lim_q.hold;
				default: rd_q <= 8'h00;
			endcase
		end
	end

	// Registered outputs.
	assign o_rd_data = rd_q;
	assign o_pwr_en = pwr_q;
	assign o_limits = lim_q;

endmodule

// File: dv/meas_front_end_model.sv
// Behavioural analog front end and classifier answering the sequencer.
`timescale 1ns/1ps
module meas_front_end_model
	import port_detection_sequencer_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_meas_req,
	input wire meas_cmd_t i_meas_cmd,
	input wire logic i_class_req,
	input wire logic [3:0] i_load,
	input wire logic i_dual,
	input wire logic [3:0] i_class,
	output logic o_meas_done,
	output meas_rsp_t o_meas_rsp,
	output logic o_class_done,
	output logic [3:0] o_class_result
);
	logic [2:0] wait_q = 3'h2; // Cycles left before the next answer.
	logic [1:0] ld; // Load kind on the addressed channel: 0 valid, 1 short, 2 open.
	logic [11:0] v; // Reading for the current step.
	initial o_meas_rsp = '0;
	initial o_class_result = '0;
	// Readings: 25k valid, short below 1V, open above 50k, single or dual pairs.
	always_comb begin
		ld = i_meas_cmd.chan ? i_load[3:2] : i_load[1:0];
		case (i_meas_cmd.step)
			STEP_I_LO: v = (ld == 2'h1) ? 12'h032 : 12'h12C;
			STEP_I_HI: v = (ld == 2'h2) ? 12'h384 : 12'h226;
			STEP_V_LO: v = 12'h064;
			STEP_V_HI: v = 12'h118;
			STEP_CC_BASE: v = 12'h1F4;
			default: v = i_dual ? 12'h1F4 : 12'h258;
		endcase
	end
	// Answers after a random delay; the released data lines toggle every cycle.
	always @(posedge i_clk) begin
		o_meas_done <= 1'b0;
		o_class_done <= 1'b0;
		o_meas_rsp <= ~o_meas_rsp;
		if ((i_meas_req || i_class_req) && !o_meas_done && !o_class_done) begin
			if (wait_q != 3'h0) begin
				wait_q <= wait_q - 3'h1;
			end else begin
				wait_q <= 3'($urandom_range(3, 0));
				o_meas_done <= i_meas_req;
				o_class_done <= !i_meas_req;
				o_meas_rsp <= '{v, 1'b0, 1'b0, 1'b0};
				o_class_result <= i_class;
			end
		end
	end
endmodule

// File: dv/port_detection_sequencer_asserts.sv
// Port-level assertions for the detection sequencer.
`timescale 1ns/1ps
module port_detection_sequencer_asserts
	import port_detection_sequencer_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rd_data,
	input wire logic o_meas_req,
	input wire meas_cmd_t o_meas_cmd,
	input wire logic i_meas_done,
	input wire meas_rsp_t i_meas_rsp,
	input wire logic [1:0] i_chan_fault,
	input wire logic [1:0] o_pwr_en
);
	logic [11:0] lo_q; // Last low forced-current reading.
	// Keeps the first reading so the slope can be judged at the second.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lo_q <= '0;
		end else if (i_meas_done && o_meas_cmd.step == STEP_I_LO) begin
			lo_q <= i_meas_rsp.value;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// A step ends with no configuration write around it.
	sequence s_done(meas_step_t st);
		o_meas_req && i_meas_done && o_meas_cmd.step == st && !i_wr && !$past(i_wr);
	endsequence
	sequence s_next(meas_step_t st);
		o_meas_req && o_meas_cmd.step == st;
	endsequence
	a_current_order: assert property (s_done(STEP_I_LO) ##0 i_meas_rsp.value >= V_SHORT_CNT
		|=> s_next(STEP_I_HI)) else $error("second forced current missing");
	a_short_abort: assert property (s_done(STEP_I_LO) ##0 i_meas_rsp.value < V_SHORT_CNT
		|=> !(o_meas_req && o_meas_cmd.step == STEP_I_HI)) else $error("short not aborted");
	a_vphase_gate: assert property (s_done(STEP_I_HI) ##0 i_meas_rsp.value > lo_q &&
		i_meas_rsp.value - lo_q > DV_50K_CNT |=> !(o_meas_req && o_meas_cmd.step == STEP_V_LO))
		else $error("voltage phase after bad slope");
	a_cc_order: assert property (s_done(STEP_CC_BASE) |=> s_next(STEP_CC_AGGR) ##0
		!o_meas_cmd.chan) else $error("check readings out of order");
	a_req_holds: assert property (o_meas_req && !i_meas_done && !i_wr && !$past(i_wr) |=>
		o_meas_req && $stable(o_meas_cmd)) else $error("step request dropped");
	a_shutdown_off: assert property (i_wr && i_addr == OFS_CTRL && i_wr_data[1:0] == 2'h0
		|-> ##2 o_pwr_en == 2'h0) else $error("power kept in shutdown");
	a_cmd_off: assert property (i_wr && i_addr == OFS_CMD && i_wr_data[2:1] == 2'h2
		|-> ##2 o_pwr_en == 2'h0) else $error("power kept after off command");
	a_fault_off: assert property (o_pwr_en[0] && i_chan_fault[0] |-> ##[1:2] !o_pwr_en[0])
		else $error("faulted channel still powered");
	a_rd_idle: assert property (!$past(i_rd) |-> o_rd_data == '0) else $error("read data stray");
endmodule
bind port_detection_sequencer port_detection_sequencer_asserts i_chk (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
	.o_rd_data(o_rd_data), .o_meas_req(o_meas_req), .o_meas_cmd(o_meas_cmd),
	.i_meas_done(i_meas_done), .i_meas_rsp(i_meas_rsp), .i_chan_fault(i_chan_fault),
	.o_pwr_en(o_pwr_en));

// File: dv/port_detection_sequencer_tb_top.sv
// Self-checking bench for the detection sequencer.
`timescale 1ns/1ps
module port_detection_sequencer_tb_top;
	import port_detection_sequencer_pkg::*;
	localparam int unsigned WAIT_CYC = 20;
	logic i_clk = 1'b0, i_rst_n = 1'b0, strap = 1'b1, spare = 1'b0;
	logic wr = 1'b0, rd = 1'b0, rd_prev = 1'b0, dual = 1'b0;
	logic meas_req, meas_done, class_req, class_done;
	logic [3:0] addr = '0, load = '0, cls = '0, class_res;
	logic [7:0] wdata = '0, rd_data;
	logic [1:0] fault = '0, disc = '0, pwr;
	meas_cmd_t meas_cmd;
	meas_rsp_t meas_rsp;
	limits_t lim;
	logic [7:0] exp_q[$]; // Expected read data, oldest first.
	int err_total = 0, checks_done = 0, cyc = 0, gap;
	always #2.5 i_clk = ~i_clk;
	port_detection_sequencer #(.REDETECT_WAIT_CYCLES(WAIT_CYC)) i_port_detection_sequencer (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_power_mode_strap(strap), .i_spare_mode_strap(spare),
		.i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
		.o_meas_req(meas_req), .o_meas_cmd(meas_cmd), .i_meas_done(meas_done),
		.i_meas_rsp(meas_rsp), .o_class_req(class_req), .i_class_done(class_done),
		.i_class_result(class_res), .i_chan_fault(fault), .i_disconnect(disc),
		.o_pwr_en(pwr), .o_limits(lim));
	meas_front_end_model i_meas_front_end_model (.i_clk(i_clk), .i_meas_req(meas_req),
		.i_meas_cmd(meas_cmd), .i_class_req(class_req), .i_load(load), .i_dual(dual),
		.i_class(cls), .o_meas_done(meas_done), .o_meas_rsp(meas_rsp),
		.o_class_done(class_done), .o_class_result(class_res));
	task automatic test_done();
		if (err_total == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge i_clk);
		rd <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wait_pwr(input logic [1:0] e);
		repeat (2) @(posedge i_clk);
		for (int n = 0; n < 3000 && pwr !== e; n++) @(posedge i_clk);
		check(pwr, e, "power");
	endtask
	task automatic wait_idle();
		int q = 0;
		for (int n = 0; n < 3000 && q < WAIT_CYC + 8; n++) begin
			@(posedge i_clk);
			q = (meas_req || class_req) ? 0 : q + 1;
		end
	endtask
	// Limits loaded in auto mode for a load kind and assigned class.
	function automatic limits_t exp_lim(input logic d, input logic [3:0] c);
		logic [7:0] t[10] = '{LIM_15W5, LIM_4W, LIM_7W, LIM_15W5, LIM_30W, LIM_32W, LIM_39W5,
			LIM_45W5, LIM_54W, LIM_15W5};
		logic [7:0] f[4] = '{LIM_45W, LIM_60W, LIM_75W, LIM_90W};
		if (d) return {(c == 4'h5) ? LIM_45W : t[c], LIM_90W, HOLD_3MA5};
		if (c inside {[5:8]}) return {t[c], f[c - 5], HOLD_3MA5};
		return {t[c], t[c], HOLD_7MA0};
	endfunction
	// Compares each read result with the oldest note.
	always @(posedge i_clk) begin
		if (rd_prev) check(rd_data, exp_q.pop_front(), "read");
		rd_prev <= rd;
	end
	// Spare strap wanders at random; a hang ends the run.
	always @(posedge i_clk) begin
		spare <= 1'($urandom);
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		void'($urandom(32'h19D0D2EA));
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd_reg(OFS_CTRL, CTRL_RST_AUTO);
		rd_reg(OFS_DET_STATUS, 8'h00);
		rd_reg(4'hF, 8'h00);
		for (int i = 0; i < 15; i++) begin
			dual <= (i >= 10);
			cls <= (i >= 10) ? 4'(i - 9) : 4'(i);
			wr_reg(OFS_CTRL, 8'h80);
			wait_pwr(2'h3);
			check(lim, exp_lim(dual, cls), "limits");
			rd_reg(OFS_PORT_STATUS, dual ? 8'h0E : 8'h0D);
		end
		disc <= 2'h1;
		repeat (3) @(posedge i_clk);
		check(pwr, 2'h2, "disconnect");
		disc <= 2'h0;
		dual <= 1'b0;
		cls <= 4'h2;
		wr_reg(OFS_CTRL, 8'h40);
		wr_reg(OFS_CTRL, 8'h4F);
		wait_pwr(2'h1);
		check(lim, exp_lim(1'b0, 4'h2), "limits");
		load <= 4'h9;
		wr_reg(OFS_CTRL, 8'h5D);
		wr_reg(OFS_CMD, 8'h04);
		wait_idle();
		wr_reg(OFS_CMD, 8'h01);
		wait_idle();
		rd_reg(OFS_DET_STATUS, 8'h61);
		rd_reg(OFS_PORT_STATUS, 8'h03);
		wr_reg(OFS_CMD, 8'h02);
		rd_reg(OFS_PORT_STATUS, 8'h13);
		wr_reg(OFS_CMD, 8'h08);
		rd_reg(OFS_PORT_STATUS, 8'h03);
		check(meas_req, 1'b0, "manual idle");
		load <= 4'h0;
		cls <= 4'h3;
		wr_reg(OFS_CTRL, 8'h5E);
		@(negedge class_req);
		gap = 0;
		while (meas_req !== 1'b1) begin
			@(posedge i_clk);
			gap++;
		end
		check(gap >= WAIT_CYC, 1'b1, "redetect gap");
		check(pwr, 2'h0, "semi power");
		rd_reg(OFS_DET_STATUS, 8'h44);
		wr_reg(OFS_CMD, 8'h02);
		check(pwr, 2'h3, "power on");
		fault <= 2'h1;
		repeat (3) @(posedge i_clk);
		check(pwr, 2'h0, "fault");
		fault <= 2'h0;
		strap <= 1'b0;
		rd_reg(OFS_CTRL, 8'h5E);
		wr_reg(OFS_CTRL, 8'h80);
		rd_reg(OFS_CTRL, CTRL_RST_OFF);
		repeat (30) @(posedge i_clk);
		check(meas_req, 1'b0, "shutdown idle");
		test_done();
	end
endmodule
